/* fwp_flash_write_protection.sv */
// serial flash write protection: latch, block ranges, freeze, one-time area
//
// Operation
// - 1024-byte one-time area, 32 lockable regions
// - one-time read like fast read
// - one-time program like page program, never erased
// - second program of 16-byte chunk disables ECC
// - out-of-range one-time program silently ignored
// - in-range program while frozen fails, sets error
// - advanced sector guard never guards one-time area
// - lock byte bit n guards region n
// - lowest lock bit guards the lock bytes
// - latch-set command sets the write latch
// - latch cleared at reset, by latch-clear and soft reset, and after nonvolatile commands
// - three range bits select protected size
// - top/bottom bit anchors protected range
// - block or sector guard refuses program/erase
// - freeze holds range bits and one-time area
// - guard pin plus disable bit lock registers
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fwp_consts.svh"

module fwp_flash_write_protection
  import fwp_pkg::*;
#(
  parameter int ADDR_BYTES = 4,             // address bytes in each command
  parameter int ARRAY_KB   = `FWP_ARRAY_KB  // main array size
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SPI_SCK,
  input  wire logic        SPI_CS_N,
  input  wire logic        SPI_SDI,
  output logic             SPI_SDO,
  output logic             SPI_SDO_OE_N,
  input  wire logic        WRITE_GUARD_N,
  input  wire logic        ASP_SECTOR_PROT,
  output logic             ARRAY_OP_GO,
  output logic      [7:0]  ARRAY_OP_CODE,
  output logic      [31:0] ARRAY_OP_ADDR,
  output logic             IRQ
);

  localparam int AW = 8 * ADDR_BYTES;       // command address width

  // elaboration-time check of what the logic can serve
  // byte size must fit the 32-bit range arithmetic, so 2 GB at most
  if (ADDR_BYTES < 3 || ADDR_BYTES > 4 || ARRAY_KB < 64 || ARRAY_KB > 2097152 ||
      (ARRAY_KB & (ARRAY_KB - 1)) != 0) begin : g_bad_param
    $error("fwp: unsupported ADDR_BYTES or ARRAY_KB");
  end

  // protected-range check for one main-array byte address
  function automatic logic range_hit(input logic [2:0] bp, input logic tb,
                                     input logic [31:0] a);
    logic [31:0] total;
    logic [31:0] size;
    total = 32'(ARRAY_KB) << 10;
    size  = total >> (3'd7 - bp);
    if (bp == 3'b000) range_hit = 1'b0;     // none
    else if (bp == 3'b111) range_hit = 1'b1; // all sectors
    else if (tb) range_hit = (a < size);    // bottom anchor
    else range_hit = (a >= total - size);   // top anchor
  endfunction

  // nonvolatile-modifying opcodes that need the latch
  function automatic logic is_nv_cmd(input logic [7:0] op);
    is_nv_cmd = (op == `FWP_OP_PAGE_PROG)  || (op == `FWP_OP_ERASE_4K)  ||
                (op == `FWP_OP_ERASE_SECT) || (op == `FWP_OP_ERASE_BULK) ||
                (op == `FWP_OP_REG_WRITE)  || (op == `FWP_OP_ANY_REG_WR) ||
                (op == `FWP_OP_OTP_PROG)   || (op == `FWP_OP_GUARD_PROG) ||
                (op == `FWP_OP_PPB_PROG)   || (op == `FWP_OP_PPB_ERASE)  ||
                (op == `FWP_OP_PASS_PROG)  || (op == `FWP_OP_LEARN_PROG);
  endfunction

  // one-time storage, nonvolatile so not touched by reset; starts erased
  logic [7:0] otp_mem [`FWP_OTP_BYTES] = '{default: `FWP_ERASED};

  // lock bit for the region of a one-time address, 0 means locked
  function automatic logic is_locked(input logic [`FWP_OTP_AW-1:0] a);
    logic [4:0] rg;
    logic [7:0] lb;
    rg = a[9:5];
    lb = otp_mem[`FWP_LOCK_BASE + {8'h00, rg[4:3]}];
    is_locked = ~lb[rg[2:0]];
  endfunction

  // pin synchronisers, three stages each
  logic [2:0] sck_s, cs_s, sdi_s;
  logic       sck_f_r, cs_f_r, sdi_f_r;     // filtered levels
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sck_s <= 3'h0;
      cs_s  <= 3'h7;
      sdi_s <= 3'h0;
    end else begin
      sck_s <= {sck_s[1:0], SPI_SCK};
      cs_s  <= {cs_s[1:0], SPI_CS_N};
      sdi_s <= {sdi_s[1:0], SPI_SDI};
    end
  end

  // a change counts only once stages two and three agree
  wire sck_f_nxt = (sck_s[2] == sck_s[1]) ? sck_s[1] : sck_f_r;
  wire cs_f_nxt  = (cs_s[2] == cs_s[1]) ? cs_s[1] : cs_f_r;
  wire sdi_f_nxt = (sdi_s[2] == sdi_s[1]) ? sdi_s[1] : sdi_f_r;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sck_f_r <= 1'b0;
      cs_f_r  <= 1'b1;
      sdi_f_r <= 1'b0;
    end else begin
      sck_f_r <= sck_f_nxt;
      cs_f_r  <= cs_f_nxt;
      sdi_f_r <= sdi_f_nxt;
    end
  end

  // frame and clock edge events
  wire frame_start = cs_f_r & ~cs_f_nxt;
  wire frame_end   = ~cs_f_r & cs_f_nxt;
  wire sck_rise    = ~cs_f_r & sck_f_nxt & ~sck_f_r;
  wire sck_fall    = ~cs_f_r & ~sck_f_nxt & sck_f_r;

  // byte assembly on rising clock edges, mode 0
  logic [6:0] shift_r;
  logic [2:0] bit_cnt_r;
  logic [9:0] byte_idx_r;                   // saturates, long pages stay safe
  logic [7:0] opcode_r;
  wire        byte_done = sck_rise & (bit_cnt_r == 3'd7);
  wire [7:0]  byte_val  = {shift_r, sdi_f_nxt};
  always_ff @(posedge CORE_CLK) begin
    if (RST || frame_start) begin
      shift_r    <= 7'h00;
      bit_cnt_r  <= 3'd0;
      byte_idx_r <= 10'd0;
    end else if (sck_rise) begin
      shift_r   <= byte_val[6:0];
      bit_cnt_r <= bit_cnt_r + 3'd1;
      if (byte_done && byte_idx_r != 10'h3ff) byte_idx_r <= byte_idx_r + 10'd1;
    end
  end

  // opcode capture, cleared at frame start so a stale one never acts
  always_ff @(posedge CORE_CLK) begin
    if (RST || frame_start) opcode_r <= 8'h00;
    else if (byte_done && byte_idx_r == 10'd0) opcode_r <= byte_val;
  end

  // decoded phases of the current frame
  wire addr_byte  = byte_done && byte_idx_r >= 10'd1 && byte_idx_r <= 10'(ADDR_BYTES);
  wire addr_last  = byte_done && byte_idx_r == 10'(ADDR_BYTES);
  wire data_byte  = byte_done && byte_idx_r > 10'(ADDR_BYTES);
  wire op_otp_prg = (opcode_r == `FWP_OP_OTP_PROG);
  wire op_otp_rd  = (opcode_r == `FWP_OP_OTP_READ);
  wire rd_phase   = op_otp_rd && byte_idx_r >= 10'(ADDR_BYTES + 2);

  // protection state
  logic       wel_r;                        // write_enable_latch
  logic       swd_r;                        // status_write_disable_bit
  logic       perr_r;                       // program error flag
  logic [2:0] bp_r;                         // range_guard_bit2..0
  logic       tb_r;                         // range_top_bottom_select
  logic       freeze_r;                     // config_one_volatile bit 0
  logic       cmd_fail_r;                   // failure seen in this frame
  fwp_otp_mode_t otp_mode_r;
  logic [7:0] reg_b0_r, reg_b1_r;           // register-write data bytes
  logic [1:0] reg_cnt_r;

  // address counter shared by one-time program and read
  logic [AW-1:0] addr_r;
  wire  [AW-1:0] addr_asm = AW'({addr_r, byte_val});
  wire           otp_in   = (addr_r < AW'(`FWP_OTP_BYTES));
  wire [`FWP_OTP_AW-1:0] oa = addr_r[`FWP_OTP_AW-1:0];
  wire           rd_load  = sck_fall && rd_phase && bit_cnt_r == 3'd0;
  always_ff @(posedge CORE_CLK) begin
    if (RST || frame_start) addr_r <= '0;
    else if (addr_byte) addr_r <= addr_asm;
    else if ((data_byte && op_otp_prg) || rd_load) addr_r <= addr_r + AW'(1);
  end

  // one-time mode chosen once the start address is known
  wire [1:0] otp_mode_sel = !wel_r ? FWP_OTP_IGNORE :
                            (addr_asm >= AW'(`FWP_OTP_BYTES)) ? FWP_OTP_IGNORE :
                            freeze_r ? FWP_OTP_FAIL : FWP_OTP_GO;
  always_ff @(posedge CORE_CLK) begin
    if (RST || frame_start) otp_mode_r <= FWP_OTP_IDLE;
    else if (addr_last && op_otp_prg) otp_mode_r <= fwp_otp_mode_t'(otp_mode_sel);
  end

  // byte programming; locked regions and out-of-range bytes are not written
  wire prog_try = data_byte && op_otp_prg && otp_mode_r == FWP_OTP_GO;
  wire prog_lck = prog_try && otp_in && is_locked(oa);
  wire prog_wr  = prog_try && otp_in && !is_locked(oa);
  always_ff @(posedge CORE_CLK) begin
    // programming only clears bits; no path ever sets them back
    if (prog_wr) otp_mem[oa] <= otp_mem[oa] & byte_val;
  end

  // check-bit tracking per 16-byte chunk
  logic [`FWP_CHUNKS-1:0] chunk_prog_r, touched_r, ecc_off_r;
  wire  [5:0] chunk = oa[9:4];
  wire        ecc_kill = prog_wr && chunk_prog_r[chunk] && !touched_r[chunk];
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      chunk_prog_r <= '0;
      touched_r    <= '0;
      ecc_off_r    <= '0;
    end else begin
      if (frame_start) touched_r <= '0;
      if (prog_wr) begin
        chunk_prog_r[chunk] <= 1'b1;        // first program writes check bits
        touched_r[chunk]    <= 1'b1;
      end
      if (ecc_kill) ecc_off_r[chunk] <= 1'b1;
    end
  end

  // read path: byte loaded on the fall after each byte boundary
  logic [7:0] tx_r;
  wire  [7:0] rd_byte = otp_in ? otp_mem[oa] : 8'h00;
  always_ff @(posedge CORE_CLK) begin
    if (RST || frame_start) tx_r <= 8'h00;
    else if (rd_load) tx_r <= rd_byte;
    else if (sck_fall && rd_phase) tx_r <= {tx_r[6:0], 1'b0};
  end
  assign SPI_SDO      = tx_r[7];
  assign SPI_SDO_OE_N = ~(rd_phase && !cs_f_r);

  // register-write data capture
  always_ff @(posedge CORE_CLK) begin
    if (RST || frame_start) begin
      reg_b0_r  <= 8'h00;
      reg_b1_r  <= 8'h00;
      reg_cnt_r <= 2'd0;
    end else if (byte_done && byte_idx_r != 10'd0 &&
                 opcode_r == `FWP_OP_REG_WRITE && reg_cnt_r != 2'd2) begin
      if (reg_cnt_r == 2'd0) reg_b0_r <= byte_val;
      else reg_b1_r <= byte_val;
      reg_cnt_r <= reg_cnt_r + 2'd1;
    end
  end

  // failures noticed during the frame
  always_ff @(posedge CORE_CLK) begin
    if (RST || frame_start) cmd_fail_r <= 1'b0;
    else if (prog_lck || (addr_last && op_otp_prg && otp_mode_sel == FWP_OTP_FAIL))
      cmd_fail_r <= 1'b1;
  end

  // end-of-frame decode
  wire fe_op    = frame_end && byte_idx_r != 10'd0;
  wire fe_nv    = fe_op && is_nv_cmd(opcode_r);
  wire fe_go    = fe_nv && wel_r;
  wire op_array = (opcode_r == `FWP_OP_PAGE_PROG) || (opcode_r == `FWP_OP_ERASE_4K) ||
                  (opcode_r == `FWP_OP_ERASE_SECT) || (opcode_r == `FWP_OP_ERASE_BULK);
  wire op_bulk  = (opcode_r == `FWP_OP_ERASE_BULK);
  wire arr_prot = op_bulk ? (bp_r != 3'b000 || ASP_SECTOR_PROT) :
                  (range_hit(bp_r, tb_r, 32'(addr_r)) || ASP_SECTOR_PROT);
  wire arr_ref  = fe_go && op_array && arr_prot;
  wire arr_ok   = fe_go && op_array && !arr_prot;
  wire reg_op   = fe_go && opcode_r == `FWP_OP_REG_WRITE && reg_cnt_r != 2'd0;
  wire reg_lock = !WRITE_GUARD_N && swd_r;
  wire reg_ref  = reg_op && reg_lock;
  wire reg_wr   = reg_op && !reg_lock;
  wire otp_end  = fe_go && op_otp_prg;

  // write enable latch
  always_ff @(posedge CORE_CLK) begin
    if (RST) wel_r <= 1'b0;
    else if (fe_op && opcode_r == `FWP_OP_LATCH_SET) wel_r <= 1'b1;
    else if (fe_op && (opcode_r == `FWP_OP_LATCH_CLR || opcode_r == `FWP_OP_SOFT_RST))
      wel_r <= 1'b0;
    else if (fe_go) wel_r <= 1'b0;
  end

  // status and configuration bits; freeze holds the range controls
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      swd_r    <= 1'b0;
      bp_r     <= 3'b000;
      tb_r     <= 1'b0;
      freeze_r <= 1'b0;
    end else if (reg_wr) begin
      swd_r <= reg_b0_r[`FWP_SR_SWD];
      if (!freeze_r) begin
        bp_r <= reg_b0_r[`FWP_SR_BP_LO +: 3];
        if (reg_cnt_r == 2'd2) tb_r <= reg_b1_r[`FWP_CR_TB];
      end
      // freeze only sets; it falls again only with reset
      if (reg_cnt_r == 2'd2 && reg_b1_r[`FWP_CR_FREEZE]) freeze_r <= 1'b1;
    end
  end

  // program error flag follows the last latched one-time program or array command
  always_ff @(posedge CORE_CLK) begin
    if (RST) perr_r <= 1'b0;
    else if (fe_op && opcode_r == `FWP_OP_SOFT_RST) perr_r <= 1'b0;
    else if (otp_end) perr_r <= cmd_fail_r;
    else if (fe_go && op_array) perr_r <= arr_prot;
  end

  // main-array request out to the array sequencer
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ARRAY_OP_GO   <= 1'b0;
      ARRAY_OP_CODE <= 8'h00;
      ARRAY_OP_ADDR <= 32'h0000_0000;
    end else begin
      ARRAY_OP_GO <= arr_ok;
      if (arr_ok) begin
        ARRAY_OP_CODE <= opcode_r;
        ARRAY_OP_ADDR <= 32'(addr_r);
      end
    end
  end

  // interrupt events, sticky, write one to clear, set wins
  logic [`FWP_IRQ_N-1:0] irq_stat_r, irq_mask_r;
  wire  [`FWP_IRQ_N-1:0] irq_ev;
  assign irq_ev[`FWP_IRQ_OTP_FAIL] = otp_end && cmd_fail_r;
  assign irq_ev[`FWP_IRQ_ARR_REF]  = arr_ref;
  assign irq_ev[`FWP_IRQ_ECC_OFF]  = ecc_kill;
  assign irq_ev[`FWP_IRQ_NO_WEL]   = fe_nv && !wel_r;
  assign irq_ev[`FWP_IRQ_REG_REF]  = reg_ref;

  // apb decode, zero wait states
  wire        apb_acc  = PSEL && PENABLE;
  wire        apb_wr   = apb_acc && PWRITE;
  wire        apb_hit  = (PADDR == `FWP_A_IRQ_STAT) || (PADDR == `FWP_A_IRQ_MASK) ||
                         (PADDR == `FWP_A_PROT)     || (PADDR == `FWP_A_OTP_ADDR) ||
                         (PADDR == `FWP_A_OTP_DATA) || (PADDR == `FWP_A_ECC_LO)   ||
                         (PADDR == `FWP_A_ECC_HI);
  logic [`FWP_OTP_AW-1:0] sw_addr_r;        // software peek pointer
  wire  [7:0] status_byte = {swd_r, perr_r, 1'b0, bp_r, wel_r, 1'b0};
  wire  [7:0] cfg_nv_byte = {2'b00, tb_r, 5'b00000};
  wire  [7:0] cfg_v_byte  = {7'h00, freeze_r};
  wire  [31:0] rd_mux =
    (PADDR == `FWP_A_IRQ_STAT) ? 32'(irq_stat_r) :
    (PADDR == `FWP_A_IRQ_MASK) ? 32'(irq_mask_r) :
    (PADDR == `FWP_A_PROT)     ? {8'h00, cfg_nv_byte, cfg_v_byte, status_byte} :
    (PADDR == `FWP_A_OTP_ADDR) ? 32'(sw_addr_r) :
    (PADDR == `FWP_A_OTP_DATA) ? {24'h000000, otp_mem[sw_addr_r]} :
    (PADDR == `FWP_A_ECC_LO)   ? ecc_off_r[31:0] :
    (PADDR == `FWP_A_ECC_HI)   ? ecc_off_r[63:32] : 32'h0000_0000;
  assign PREADY  = apb_acc;
  assign PSLVERR = apb_acc && !apb_hit;

  // read data taken in the setup cycle so it is a flop in the access cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) PRDATA <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE) PRDATA <= rd_mux;
  end

  // software registers
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      sw_addr_r  <= '0;
    end else begin
      if (apb_wr && PADDR == `FWP_A_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~PWDATA[`FWP_IRQ_N-1:0]) | irq_ev;
      else
        irq_stat_r <= irq_stat_r | irq_ev;
      if (apb_wr && PADDR == `FWP_A_IRQ_MASK) irq_mask_r <= PWDATA[`FWP_IRQ_N-1:0];
      if (apb_wr && PADDR == `FWP_A_OTP_ADDR) sw_addr_r <= PWDATA[`FWP_OTP_AW-1:0];
    end
  end
  assign IRQ = |(irq_stat_r & irq_mask_r);

  // checks
  a_wel_set_cmd: assert property (@(posedge CORE_CLK) disable iff (RST)
    fe_op && opcode_r == `FWP_OP_LATCH_SET |=> wel_r)
    else $error("latch not set by latch-set command");
  a_wel_nv_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
    fe_go |=> !wel_r ##1 (!wel_r || $past(fe_op)))
    else $error("latch not cleared after nonvolatile command");
  a_freeze_hold_bp: assert property (@(posedge CORE_CLK) disable iff (RST)
    freeze_r |=> $stable(bp_r) && $stable(tb_r) && freeze_r)
    else $error("range bits changed while frozen");
  a_otp_frozen_err: assert property (@(posedge CORE_CLK) disable iff (RST)
    otp_end && otp_mode_r == FWP_OTP_FAIL |=> perr_r && irq_stat_r[`FWP_IRQ_OTP_FAIL])
    else $error("frozen one-time program did not fail");
  a_otp_range_quiet: assert property (@(posedge CORE_CLK) disable iff (RST)
    otp_end && otp_mode_r == FWP_OTP_IGNORE |=> !perr_r)
    else $error("out-of-range one-time program raised error");
  a_guard_pin_lock: assert property (@(posedge CORE_CLK) disable iff (RST)
    reg_op && !WRITE_GUARD_N && swd_r |=> $stable(bp_r) && $stable(tb_r) && swd_r)
    else $error("registers altered under guard pin");
  a_array_refuse: assert property (@(posedge CORE_CLK) disable iff (RST)
    fe_go && op_array && arr_prot |=> !ARRAY_OP_GO && perr_r)
    else $error("protected sector not refused");
  a_no_latch_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
    fe_nv && !wel_r |=> !ARRAY_OP_GO && $stable(bp_r) && $stable(freeze_r))
    else $error("command acted without write latch");
  a_ecc_second_off: assert property (@(posedge CORE_CLK) disable iff (RST)
    ecc_kill |=> ecc_off_r[$past(chunk)] ##1 ecc_off_r[$past(chunk, 2)])
    else $error("check bits not disabled on reprogram");
  a_locked_no_write: assert property (@(posedge CORE_CLK) disable iff (RST)
    prog_lck |-> !prog_wr ##1 cmd_fail_r)
    else $error("locked region programmed");

endmodule

/* fwp_consts.svh */
// constants for the flash write-protection block
`ifndef FWP_CONSTS_SVH
`define FWP_CONSTS_SVH

// one-time area geometry
`define FWP_OTP_BYTES     1024
`define FWP_OTP_AW        10
`define FWP_REGION_BYTES  32
`define FWP_CHUNK_BYTES   16
`define FWP_CHUNKS        64
`define FWP_LOCK_BASE     10'h010
`define FWP_ERASED        8'hff

// main array size in kilobytes and the one-64th step
`define FWP_ARRAY_KB      65536
`define FWP_RANGE_STEP_KB 1024

// serial opcodes
`define FWP_OP_LATCH_SET  8'h06
`define FWP_OP_LATCH_CLR  8'h04
`define FWP_OP_SOFT_RST   8'hf0
`define FWP_OP_PAGE_PROG  8'h02
`define FWP_OP_ERASE_4K   8'h20
`define FWP_OP_ERASE_SECT 8'hd8
`define FWP_OP_ERASE_BULK 8'h60
`define FWP_OP_REG_WRITE  8'h01
`define FWP_OP_ANY_REG_WR 8'h71
`define FWP_OP_OTP_PROG   8'h42
`define FWP_OP_OTP_READ   8'h4b
`define FWP_OP_GUARD_PROG 8'h2f
`define FWP_OP_PPB_PROG   8'hfd
`define FWP_OP_PPB_ERASE  8'he4
`define FWP_OP_PASS_PROG  8'he8
`define FWP_OP_LEARN_PROG 8'h43

// status and configuration byte fields
`define FWP_SR_SWD        7
`define FWP_SR_PERR       6
`define FWP_SR_BP_LO      2
`define FWP_SR_WEL        1
`define FWP_CR_TB         5
`define FWP_CR_FREEZE     0

// apb map
`define FWP_A_IRQ_STAT    8'h00
`define FWP_A_IRQ_MASK    8'h04
`define FWP_A_PROT        8'h08
`define FWP_A_OTP_ADDR    8'h0c
`define FWP_A_OTP_DATA    8'h10
`define FWP_A_ECC_LO      8'h14
`define FWP_A_ECC_HI      8'h18

// interrupt bits
`define FWP_IRQ_N         5
`define FWP_IRQ_OTP_FAIL  0
`define FWP_IRQ_ARR_REF   1
`define FWP_IRQ_ECC_OFF   2
`define FWP_IRQ_NO_WEL    3
`define FWP_IRQ_REG_REF   4

`endif

/* fwp_pkg.sv */
// types for the flash write-protection block
package fwp_pkg;
  typedef enum logic [1:0] {
    FWP_OTP_IDLE   = 2'b00,
    FWP_OTP_IGNORE = 2'b01,
    FWP_OTP_FAIL   = 2'b10,
    FWP_OTP_GO     = 2'b11
  } fwp_otp_mode_t;
endpackage

/* fwp_host_model.sv */
// host-side serial model: mode 0 frames, clock still between frames
`timescale 1ns/1ps

module fwp_host_model (
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  logic [7:0] tx_q[$]; // bytes out, msb first
  logic [7:0] rx_q[$]; // bytes sampled back

  // idle: deselected, clock low
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b1;
  end

  // one whole frame, 400 ns bit time
  task automatic frame();
    logic [7:0] v;
    rx_q.delete();
    #37 cs_n = 1'b0; // odd offset keeps phase unrelated to core clock
    foreach (tx_q[i]) begin
      for (int k = 7; k >= 0; k--) begin
        sdi = tx_q[i][k]; // set while clock low
        #200 sck = 1'b1;
        v = {v[6:0], sdo};
        #200 sck = 1'b0;
      end
      rx_q.push_back(v);
    end
    #200 cs_n = 1'b1;
    sdi = ~sdi; // released line must not show a stale level
    #2000;      // gap lets the filtered frame end land
  endtask
endmodule

/* tb_top.sv */
// bench for the write-protection block: apb and serial scenarios
`timescale 1ns/1ps
`include "fwp_consts.svh"

module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        guard_n = 1'b1; // write-guard pin
  logic        advanced_sector_guard = 1'b0;     // sector guard result
  logic [31:0] prdata, op_addr, r;
  logic [7:0]  op_code;
  logic        pready, pslverr, err, sck, cs_n, sdi, sdo, sdo_oe_n, go, irq;
  int          error_cnt = 0;
  int          checks = 0;
  int          go_cnt = 0; // accepted array ops

  always #25 clk = ~clk;

  // small array keeps range math short
  fwp_flash_write_protection #(.ARRAY_KB(64)) dut (
    .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_SDI(sdi), .SPI_SDO(sdo),
    .SPI_SDO_OE_N(sdo_oe_n), .WRITE_GUARD_N(guard_n), .ASP_SECTOR_PROT(advanced_sector_guard),
    .ARRAY_OP_GO(go), .ARRAY_OP_CODE(op_code), .ARRAY_OP_ADDR(op_addr), .IRQ(irq));

  fwp_host_model host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  // count one-cycle go pulses
  always @(posedge clk) if (go === 1'b1) go_cnt <= go_cnt + 1;

  task automatic report_and_stop();
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, bounded wait for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk); // a write lands before any output is judged
  endtask

  // frame: opcode, optional 4 address bytes, nd bytes of d from the top
  task automatic spi(input logic [7:0] op, input int na, input logic [31:0] a,
                     input int nd, input logic [15:0] d);
    host.tx_q.delete();
    host.tx_q.push_back(op);
    if (na > 0) for (int i = 3; i >= 0; i--) host.tx_q.push_back(a[8*i+:8]);
    for (int i = 0; i < nd; i++) host.tx_q.push_back(d[8*(nd-1-i)+:8]);
    host.frame();
  endtask

  task automatic we();
    spi(`FWP_OP_LATCH_SET, 0, 0, 0, 0);
  endtask

  task automatic prog(input logic [7:0] op, input logic [31:0] a, input logic [7:0] d);
    we();
    spi(op, 4, a, 1, {8'h00, d});
  endtask

  task automatic wrr(input logic [7:0] s, input logic [7:0] c);
    we();
    spi(`FWP_OP_REG_WRITE, 0, 0, 2, {s, c});
  endtask

  task automatic peek(input logic [9:0] a);
    apb(1'b1, `FWP_A_OTP_ADDR, {22'h0, a});
    apb(1'b0, `FWP_A_OTP_DATA, 0);
  endtask

  // reset values, unmapped access, latch set and clear
  task automatic t_basic();
    apb(1'b0, `FWP_A_PROT, 0);
    chk(r, 32'h0);
    apb(1'b0, 8'h1c, 0);
    chk(err, 1'b1);
    we();
    apb(1'b0, `FWP_A_PROT, 0);
    chk(r, 32'h2);
    spi(`FWP_OP_LATCH_CLR, 0, 0, 0, 0);
    apb(1'b0, `FWP_A_PROT, 0);
    chk(r, 32'h0);
  endtask

  // program without latch is dropped; interrupt raise, mask, clear
  task automatic t_nolatch();
    int n;
    n = go_cnt;
    apb(1'b1, `FWP_A_IRQ_MASK, 32'h1f);
    spi(`FWP_OP_PAGE_PROG, 4, 32'h0, 1, 16'h00ff);
    chk(go_cnt, n);
    apb(1'b0, `FWP_A_IRQ_STAT, 0);
    chk(r, 32'h8);
    chk(irq, 1'b1);
    apb(1'b1, `FWP_A_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, `FWP_A_IRQ_STAT, 32'h1f);
    apb(1'b0, `FWP_A_IRQ_STAT, 0);
    chk(r, 32'h0);
  endtask

  // range codes 1 to 7 at the top, then bottom anchor, bulk erase, then sector guard
  task automatic t_range();
    int n;
    for (int c = 1; c < 8; c++) begin
      wrr({3'b0, c[2:0], 2'b0}, 8'h00);
      n = go_cnt;
      prog(`FWP_OP_PAGE_PROG, 32'hffff, 8'h00);
      chk(go_cnt, n);
      if (c < 7) begin
        prog(`FWP_OP_PAGE_PROG, 32'hffff - (32'd1024 << (c - 1)), 8'h00);
        chk(go_cnt, n + 1);
      end
    end
    wrr(8'h04, 8'h20);
    n = go_cnt;
    prog(`FWP_OP_PAGE_PROG, 32'h0, 8'h00);
    chk(go_cnt, n);
    prog(`FWP_OP_PAGE_PROG, 32'h400, 8'h00);
    chk(go_cnt, n + 1);
    chk(op_code, `FWP_OP_PAGE_PROG);
    chk(op_addr, 32'h400);
    we();
    spi(`FWP_OP_ERASE_BULK, 0, 0, 0, 0);
    chk(go_cnt, n + 1);
    wrr(8'h00, 8'h20);
    apb(1'b1, `FWP_A_IRQ_STAT, 32'h1f);
    @(posedge clk) advanced_sector_guard <= 1'b1;
    prog(`FWP_OP_PAGE_PROG, 32'h400, 8'h00);
    chk(go_cnt, n + 1);
    apb(1'b0, `FWP_A_IRQ_STAT, 0);
    chk(r[1], 1'b1);
  endtask

  // guard pin with disable bit refuses register writes; error flag still up
  task automatic t_guard();
    wrr(8'h80, 8'h20);
    @(posedge clk) guard_n <= 1'b0;
    wrr(8'h1c, 8'h20);
    apb(1'b0, `FWP_A_PROT, 0);
    chk(r[7:0], 8'hc0);
    apb(1'b0, `FWP_A_IRQ_STAT, 0);
    chk(r[4], 1'b1);
    @(posedge clk) guard_n <= 1'b1;
    wrr(8'h00, 8'h20);
  endtask

  // one-time area: program, ecc, read, range, lock bits (sector guard still high)
  task automatic t_otp();
    prog(`FWP_OP_OTP_PROG, 32'h20, 8'h5a);
    peek(10'h20);
    chk(r, 32'h5a);
    prog(`FWP_OP_OTP_PROG, 32'h21, 8'h3c);
    apb(1'b0, `FWP_A_ECC_LO, 0);
    chk(r, 32'h4);
    spi(`FWP_OP_OTP_READ, 4, 32'h20, 2, 16'h0);
    chk(host.rx_q[6], 8'h5a);
    chk(sdo_oe_n, 1'b1);
    prog(`FWP_OP_OTP_PROG, 32'h400, 8'h00);
    apb(1'b0, `FWP_A_PROT, 0);
    chk(r[6], 1'b0);
    prog(`FWP_OP_OTP_PROG, 32'h10, 8'hfd);
    prog(`FWP_OP_OTP_PROG, 32'h22, 8'h00);
    peek(10'h22);
    chk(r, 32'hff);
    prog(`FWP_OP_OTP_PROG, 32'h40, 8'h11);
    peek(10'h40);
    chk(r, 32'h11);
    prog(`FWP_OP_OTP_PROG, 32'h10, 8'hfc);
    prog(`FWP_OP_OTP_PROG, 32'h11, 8'h00);
    peek(10'h11);
    chk(r, 32'hff);
  endtask

  // soft reset clears the error flag; freeze holds range bits and the one-time area
  task automatic t_freeze();
    spi(`FWP_OP_SOFT_RST, 0, 0, 0, 0);
    wrr(8'h04, 8'h20);
    wrr(8'h04, 8'h21);
    wrr(8'h08, 8'h21);
    apb(1'b0, `FWP_A_PROT, 0);
    chk(r[15:0], 16'h0104);
    prog(`FWP_OP_OTP_PROG, 32'h300, 8'h00);
    apb(1'b0, `FWP_A_PROT, 0);
    chk(r[6], 1'b1);
    peek(10'h300);
    chk(r, 32'hff);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_basic();
    t_nolatch();
    t_range();
    t_guard();
    t_otp();
    t_freeze();
    report_and_stop();
  end
endmodule
